// ===== bench/adc_serial_pin_interface_props.sv
// Assertion checker for the converter serial pin interface.
// Bound to the core and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module adc_serial_pin_interface_props (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic chipSelectN,
   input wire logic convertStartN,
   input wire logic dataOut,
   input wire logic dataOutEnN,
   input wire logic endOfConvN,
   input wire logic startPinEnabled,
   input wire logic diffMode,
   input wire logic bipolarMode,
   input wire logic [1:0] clockMode,
   input wire logic [3:0] channelSel
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence csFall; $fell(chipSelectN); endsequence
   sequence eocUpSoon; ##[1:5] endOfConvN; endsequence
   AST_OE_FOLLOWS_CS: assert property (dataOutEnN == chipSelectN)
      else $error("output enable differs from chip select");
   AST_EOC_UP_ON_CS: assert property (csFall |-> eocUpSoon)
      else $error("end of conversion not cleared by select");
   AST_EOC_UP_ON_START: assert property (
      $fell(convertStartN) && startPinEnabled |-> eocUpSoon)
      else $error("end of conversion not cleared by start pin");
   AST_EOC_MODE_EXT: assert property (
      clockMode == 2'h3 && $past(clockMode) == 2'h3 |-> endOfConvN)
      else $error("end of conversion low in external clock mode");
   AST_START_PIN_MODE: assert property (startPinEnabled == !clockMode[1])
      else $error("start pin enable disagrees with clock mode");
   AST_BIPOLAR_DIFF: assert property (bipolarMode |-> diffMode)
      else $error("bipolar range on single-ended input");
   AST_DOUT_HOLD_HIGH: assert property (
      !dataOutEnN && $past(!dataOutEnN) && sclk && $past(sclk) |-> $stable(dataOut))
      else $error("data out moved while serial clock high");
   AST_RESET_VALUES: assert property (disable iff (1'b0)
      !nrst |=> endOfConvN && clockMode == 2'h2 && channelSel == 4'h0)
      else $error("wrong values after reset");
endmodule
bind adc_serial_pin_interface adc_serial_pin_interface_props adc_serial_pin_interface_props_inst (.*);
`default_nettype wire

// ===== bench/spi_host_model.sv
// Host serial master model for the converter's serial pins.
// Mode 0 framing; its clock runs only inside frames.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
   output logic sclk,
   output logic chipSelectN,
   output logic dataIn,
   input wire logic dataOut
);
   // Select starts low for 1 ns so its rising edge clears the link's frame
   // state, as a host's select line does once it comes up idle.
   initial begin
      sclk = 1'b0;
      chipSelectN = 1'b0;
      dataIn = 1'b0;
      #1 chipSelectN = 1'b1;
   end
   task automatic select(input logic on);
      #20 chipSelectN = !on;
      dataIn = ~dataIn;
      #20;
   endtask
   task automatic byteIo(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         dataIn = tx[i];
         #7.5 sclk = 1'b1;
         rx[i] = dataOut;
         #7.5 sclk = 1'b0;
      end
   endtask
   // Cut frame: a few bits, then select is released mid-byte
   task automatic partial(input int n);
      select(1'b1);
      for (int i = 0; i < n; i++) begin
         dataIn = 1'b1;
         #7.5 sclk = 1'b1;
         #7.5 sclk = 1'b0;
      end
      select(1'b0);
   endtask
endmodule
`default_nettype wire

// ===== bench/tb_adc_serial_pin_interface.sv
// Self-checking bench for the converter serial pin interface.
// Drives the link through the host model; results checked against a queue model.
`timescale 1ns/10ps
`default_nettype none
module tb_adc_serial_pin_interface;
   import adc_serial_pkg::*;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic convertStartN = 1'b1;
   logic [9:0] sampleValue = 10'h000;
   wire logic sclk, chipSelectN, dataIn, dataOut, dataOutEnN, endOfConvN;
   wire logic startPinEnabled, refNegEnabled, diffMode, bipolarMode;
   wire logic [3:0] channelSel;
   wire logic [1:0] clockMode;
   // Released line shows the inverse so a stale bit cannot pass
   wire logic doutWire = dataOutEnN ? ~dataOut : dataOut;
   wire logic [5:0] setupView = {clockMode, startPinEnabled, refNegEnabled,
      diffMode, bipolarMode};
   int n_errors = 0;
   int comparisons = 0;
   int rng = 96650;
   int tmp;
   int expQ[$];
   logic [7:0] hi, lo, cfg;
   logic [3:0] ch;
   logic [5:0] expSet;
   always #2.5 mclk = ~mclk;
   adc_serial_pin_interface adc_serial_pin_interface_inst (.mclk(mclk), .nrst(nrst),
      .sclk(sclk), .chipSelectN(chipSelectN), .dataIn(dataIn), .dataOut(dataOut),
      .dataOutEnN(dataOutEnN), .endOfConvN(endOfConvN), .convertStartN(convertStartN),
      .sampleValue(sampleValue), .channelSel(channelSel), .startPinEnabled(startPinEnabled),
      .refNegEnabled(refNegEnabled), .diffMode(diffMode), .bipolarMode(bipolarMode),
      .clockMode(clockMode));
   spi_host_model spi_host_model_inst (.sclk(sclk), .chipSelectN(chipSelectN),
      .dataIn(dataIn), .dataOut(doutWire));
   function int xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   task automatic print_verdict();
      $display("%0d comparisons, %0d mismatches", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic waitEoc();
      int k;
      k = 0;
      while (endOfConvN !== 1'b0 && k < 2000) begin
         @(negedge mclk);
         k++;
      end
      check(endOfConvN, 1'b0, "end of conversion");
      if (k == 2000) print_verdict();
   endtask
   task automatic sendCmd(input logic [7:0] c);
      spi_host_model_inst.select(1'b1);
      spi_host_model_inst.byteIo(c, lo);
      spi_host_model_inst.select(1'b0);
      repeat (8) @(negedge mclk);
   endtask
   task automatic readResult();
      int e;
      e = expQ.pop_front();
      spi_host_model_inst.select(1'b1);
      repeat (6) @(negedge mclk);
      check(endOfConvN, 1'b1, "flag after select");
      spi_host_model_inst.byteIo(8'h00, hi);
      spi_host_model_inst.byteIo(8'h00, lo);
      spi_host_model_inst.select(1'b0);
      check({hi, lo}, {4'h0, e[9:0], 2'b00}, "result");
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      repeat (4) @(negedge mclk);
      check({endOfConvN, clockMode, channelSel}, {1'b1, 2'h2, 4'h0}, "reset");
      $display("reset test done");
      for (int m = 0; m < 4; m++) begin
         tmp = xs();
         cfg = {2'b01, m[1:0], tmp[3:0]};
         sendCmd(cfg);
         expSet = {cfg[5:4], !cfg[5], cfg[3], cfg[1], cfg[1] & cfg[0]};
         check(setupView, expSet, "setup");
      end
      $display("setup test done");
      spi_host_model_inst.partial(3);
      sendCmd(8'h60);
      check(clockMode, 2'h2, "mode after cut frame");
      $display("cut frame test done");
      for (int c = 0; c < 3; c++) begin
         tmp = xs();
         ch = (c == 2) ? 4'hF : tmp[7:4];
         @(posedge mclk) sampleValue <= tmp[9:0];
         expQ.push_back(tmp);
         sendCmd({1'b1, ch, 3'b000});
         check(channelSel, ch, "channel");
         waitEoc();
         readResult();
      end
      $display("serial conversion test done");
      sendCmd(8'h40);
      tmp = xs();
      @(posedge mclk) sampleValue <= tmp[9:0];
      expQ.push_back(tmp);
      @(posedge mclk) convertStartN <= 1'b0;
      repeat (10) @(posedge mclk);
      convertStartN <= 1'b1;
      waitEoc();
      readResult();
      $display("start pin test done");
      print_verdict();
   end
endmodule
`default_nettype wire

// ===== common/adc_serial_defines.svh
// Constants for the serial pin interface of the 10-bit multichannel converter.
// Included by the package and the core; holds definitions only.
`ifndef ADC_SERIAL_DEFINES_SVH
`define ADC_SERIAL_DEFINES_SVH

`define CMD_BITS 8
`define RESULT_BITS 10
`define FRAME_BITS 16
`define LEAD_ZEROS 4
`define SUB_BITS 2
`define CHAN_COUNT 16
`define CHAN_BITS 4
// Command byte: bit 7 high selects a conversion request
`define CMD_CONV_BIT 7
// Conversion byte: channel number in bits 6:3
`define CONV_CHAN_HI 6
`define CONV_CHAN_LO 3
// Setup byte: bits 7:6 = 2'b01 marks a setup write
`define SETUP_TAG_HI 7
`define SETUP_TAG_LO 6
`define SETUP_TAG 2'h1
`define SETUP_CLKMODE_HI 5
`define SETUP_CLKMODE_LO 4
`define SETUP_REFSEL_HI 3
`define SETUP_REFSEL_LO 2
`define SETUP_DIFF_BIT 1
`define SETUP_BIP_BIT 0
`define CLKMODE_RESET 2'h2
`define REFSEL_RESET 2'h0
// Conversion time in ns and cycles at 200 MHz (longest: rounds down)
`define CONV_TIME_NS 7000
`define CLK_PERIOD_NS 5
`define CONV_CYCLES (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define START_CHAN 15
`define REFN_CHAN 14

`endif

// ===== common/adc_serial_pkg.sv
// Types shared by the serial pin interface core.
// Assumes the defines header sits on the include path.
`default_nettype none
`include "adc_serial_defines.svh"

package adc_serial_pkg;
   typedef enum logic [1:0] {
      CLK_MODE_PIN_SCAN = 2'h0,
      CLK_MODE_PIN_SINGLE = 2'h1,
      CLK_MODE_SERIAL = 2'h2,
      CLK_MODE_EXTERNAL = 2'h3
   } clock_mode_select_t;

   typedef enum logic [2:0] {
      CONV_IDLE = 3'h1,
      CONV_BUSY = 3'h2,
      CONV_DONE = 3'h4
   } conv_state_t;
endpackage

`default_nettype wire

// ===== core/adc_serial_pin_interface.sv
// Serial port, conversion start and end-of-conversion logic of the converter.
// Assumes: sclk is the host's clock and runs only with chip select low; the
// analog SAR core is modelled by the sample input and the conversion timer.
`timescale 1ns/10ps
`default_nettype none
`include "adc_serial_defines.svh"

module adc_serial_pin_interface
   import adc_serial_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic chipSelectN,
   input wire logic dataIn,
   output logic dataOut,
   output logic dataOutEnN,
   output logic endOfConvN,
   input wire logic convertStartN,
   input wire logic [`RESULT_BITS-1:0] sampleValue,
   output logic [`CHAN_BITS-1:0] channelSel,
   output logic startPinEnabled,
   output logic refNegEnabled,
   output logic diffMode,
   output logic bipolarMode,
   output logic [1:0] clockMode
);

   // ----------------------------------------------------------------
   // Link domain: shift register on sclk
   // ----------------------------------------------------------------
   // Frame reset comes straight from chipSelectN so no sclk edge is needed
   // to clear state between frames.
   logic [2:0] bitCnt_r;
   logic [`CMD_BITS-1:0] shiftIn_r;
   logic byteTgl_r;
   logic [`CMD_BITS-1:0] byteHold_r;
   logic outLoaded_r;
   logic linkRst_r;
   logic [`FRAME_BITS-1:0] shiftOut_r;
   logic [`FRAME_BITS-1:0] frameWord;
   logic [`RESULT_BITS-1:0] resultHold_r, resultHold_nxt;

   always_ff @(posedge sclk or posedge chipSelectN) begin
      if (chipSelectN) begin
         bitCnt_r <= 3'h0;
         shiftIn_r <= 8'h00;
      end else begin
         shiftIn_r <= {shiftIn_r[`CMD_BITS-2:0], dataIn};
         bitCnt_r <= bitCnt_r + 3'h1;
      end
   end

   // Registered copy of nrst clears the toggle without glitches; the host
   // keeps sclk still while the mclk side is in reset.
   always_ff @(posedge mclk) begin
      linkRst_r <= !nrst;
   end

   // Completed byte handed to mclk by toggle
   always_ff @(posedge sclk or posedge linkRst_r) begin
      if (linkRst_r) begin
         byteTgl_r <= 1'b0;
      end else if (!chipSelectN && bitCnt_r == 3'h7) begin
         byteTgl_r <= ~byteTgl_r;
      end
   end

   // Byte held until the next one, so mclk reads it well after it settles
   always_ff @(posedge sclk) begin
      if (!chipSelectN && bitCnt_r == 3'h7) begin
         byteHold_r <= {shiftIn_r[`CMD_BITS-2:0], dataIn};
      end
   end

   // Output frame: 4 zeros, result, 2 sub-bits (sub-bits read zero)
   assign frameWord = {{`LEAD_ZEROS{1'b0}}, resultHold_r, {`SUB_BITS{1'b0}}};

   always_ff @(negedge sclk or posedge chipSelectN) begin
      if (chipSelectN) begin
         shiftOut_r <= 16'h0000;
         outLoaded_r <= 1'b0;
      end else if (!outLoaded_r) begin
         shiftOut_r <= {frameWord[`FRAME_BITS-2:0], 1'b0};
         outLoaded_r <= 1'b1;
      end else begin
         shiftOut_r <= {shiftOut_r[`FRAME_BITS-2:0], 1'b0};
      end
   end

   // Bit 15 is always a lead zero, so the cleared register shows it from the
   // chip select fall until the first falling sclk.
   assign dataOut = shiftOut_r[`FRAME_BITS-1];
   assign dataOutEnN = chipSelectN;

   // ----------------------------------------------------------------
   // Crossings into mclk
   // ----------------------------------------------------------------
   logic [2:0] tglSync_r;
   logic [1:0] csSync_r;
   logic [2:0] startSync_r;
   logic csLow_d_r;

   always_ff @(posedge mclk) begin
      tglSync_r <= {tglSync_r[1:0], byteTgl_r};
      csSync_r <= {csSync_r[0], chipSelectN};
      startSync_r <= {startSync_r[1:0], convertStartN};
      csLow_d_r <= csSync_r[1];
   end

   logic byteEvt, csFall, startFall;
   assign byteEvt = tglSync_r[2] ^ tglSync_r[1];
   assign csFall = csLow_d_r & ~csSync_r[1];
   assign startFall = startSync_r[2] & ~startSync_r[1] & startPinEnabled;

   // ----------------------------------------------------------------
   // Setup and conversion control
   // ----------------------------------------------------------------
   // resultHold_r is read by the sclk side only while a frame shifts; the
   // host waits for endOfConvN, so the word is stable by then.
   conv_state_t state_r, state_nxt;
   logic [1:0] clockMode_r, clockMode_nxt;
   logic [1:0] refSel_r, refSel_nxt;
   logic diff_r, diff_nxt, bip_r, bip_nxt;
   logic [`CHAN_BITS-1:0] chan_r, chan_nxt;
   logic [12:0] timer_r, timer_nxt;
   logic eocN_r, eocN_nxt;
   logic [`CMD_BITS-1:0] cmd;

   assign cmd = byteHold_r;

   always_comb begin
      state_nxt = state_r;
      clockMode_nxt = clockMode_r;
      refSel_nxt = refSel_r;
      diff_nxt = diff_r;
      bip_nxt = bip_r;
      chan_nxt = chan_r;
      timer_nxt = timer_r;
      resultHold_nxt = resultHold_r;
      eocN_nxt = eocN_r;
      if (csFall || startFall) begin
         eocN_nxt = 1'b1;
      end
      if (byteEvt) begin
         if (cmd[`CMD_CONV_BIT]) begin
            chan_nxt = cmd[`CONV_CHAN_HI:`CONV_CHAN_LO];
            if (clockMode_r == CLK_MODE_SERIAL) begin
               state_nxt = CONV_BUSY;
               timer_nxt = 13'(`CONV_CYCLES);
            end
         end else if (cmd[`SETUP_TAG_HI:`SETUP_TAG_LO] == `SETUP_TAG) begin
            clockMode_nxt = cmd[`SETUP_CLKMODE_HI:`SETUP_CLKMODE_LO];
            refSel_nxt = cmd[`SETUP_REFSEL_HI:`SETUP_REFSEL_LO];
            diff_nxt = cmd[`SETUP_DIFF_BIT];
            bip_nxt = cmd[`SETUP_DIFF_BIT] & cmd[`SETUP_BIP_BIT];
         end
      end
      if (startFall && (clockMode_r == CLK_MODE_PIN_SCAN ||
                        clockMode_r == CLK_MODE_PIN_SINGLE)) begin
         state_nxt = CONV_BUSY;
         timer_nxt = 13'(`CONV_CYCLES);
      end
      case (state_r)
         CONV_IDLE: begin
         end
         CONV_BUSY: begin
            if (timer_r == 13'h0001) begin
               state_nxt = CONV_DONE;
            end else begin
               timer_nxt = timer_r - 13'h0001;
            end
         end
         CONV_DONE: begin
            resultHold_nxt = sampleValue;
            if (clockMode_r != CLK_MODE_EXTERNAL) begin
               eocN_nxt = 1'b0;
            end
            state_nxt = CONV_IDLE;
         end
         default: begin
            state_nxt = CONV_IDLE;
         end
      endcase
      if (clockMode_r == CLK_MODE_EXTERNAL) begin
         eocN_nxt = 1'b1;
      end
      if (!nrst) begin
         state_nxt = CONV_IDLE;
         clockMode_nxt = `CLKMODE_RESET;
         refSel_nxt = `REFSEL_RESET;
         diff_nxt = 1'b0;
         bip_nxt = 1'b0;
         chan_nxt = 4'h0;
         timer_nxt = 13'h0000;
         resultHold_nxt = 10'h000;
         eocN_nxt = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      state_r <= state_nxt;
      clockMode_r <= clockMode_nxt;
      refSel_r <= refSel_nxt;
      diff_r <= diff_nxt;
      bip_r <= bip_nxt;
      chan_r <= chan_nxt;
      timer_r <= timer_nxt;
      resultHold_r <= resultHold_nxt;
      eocN_r <= eocN_nxt;
   end

   // Start pin replaces channel 15 only in the pin-started modes
   assign startPinEnabled = (clockMode_r == CLK_MODE_PIN_SCAN) ||
                            (clockMode_r == CLK_MODE_PIN_SINGLE);
   assign refNegEnabled = refSel_r[1];
   assign channelSel = chan_r;
   assign diffMode = diff_r;
   assign bipolarMode = bip_r;
   assign clockMode = clockMode_r;
   assign endOfConvN = eocN_r;

endmodule

`default_nettype wire
